// [design/emsi_top.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Status indicators, rate choice, addressing and control source
// Assumes: Status and config inputs come from same-clock logic; PHY pins do not
// Notes: Every output is a field of the registered state struct
//////////////////////////////////////////////////////////////////////////////
module emsi_top #(
  parameter int unsigned BLINK_PERIOD = emsi_pkg::BLINK_CYCLES,
  parameter logic [47:0] MAC_ADDR = emsi_pkg::MAC_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Firmware status
  input wire emsi_pkg::emsi_status_type status,
  // PHY pins
  input wire emsi_pkg::emsi_phy_type phy_in,
  input wire logic [1:0] rx_frame,
  // Rate configuration
  input wire logic autoneg_en,
  input wire emsi_pkg::emsi_rate_type forced_rate,
  // Addressing
  input wire logic dhcp_en,
  input wire emsi_pkg::emsi_ip_type dhcp_ip,
  input wire logic dhcp_lease_valid,
  input wire emsi_pkg::emsi_ip_type static_ip,
  input wire logic static_ip_valid,
  // Control data sources
  input wire logic master_valid,
  input wire logic [15:0] master_ctrl,
  input wire logic web_wr,
  input wire logic [15:0] web_ctrl,
  // Indicators
  output emsi_pkg::emsi_led_type ms_led,
  output emsi_pkg::emsi_led_type ns_led,
  output emsi_pkg::emsi_led_type link_led,
  // Results
  output emsi_pkg::emsi_rate_type [1:0] port_rate,
  output emsi_pkg::emsi_ip_type ip_cfg,
  output logic ip_valid,
  output logic [15:0] ctrl_word,
  output logic [1:0] fwd_to_port,
  output logic [47:0] mac_addr
);
  import emsi_pkg::*;

  emsi_state_type r_reg, r_next;
  logic phase;
  logic tick;
  logic major_now;
  emsi_led_type flash_green, flash_red, alt_gr;

  //////////////////////////////////////////////////////////////////////////
  // Timebase shared by all flashing patterns
  emsi_blink #(
    .PERIOD(BLINK_PERIOD)
  ) u_blink (
    .clk(clk),
    .resetn(resetn),
    .phase(phase),
    .tick(tick)
  );

  // Best common rate; with auto off the forced setting is used as is
  function automatic emsi_rate_type resolve_rate(
    input logic [3:0] abil,
    input logic auto_en,
    input emsi_rate_type forced
  );
    emsi_rate_type res;
    res = forced;
    if (auto_en) begin
      if (abil[ABIL_100FD]) begin
        res = '{speed: SPD_100, duplex: DUP_FULL};
      end else if (abil[ABIL_100HD]) begin
        res = '{speed: SPD_100, duplex: DUP_HALF};
      end else if (abil[ABIL_10FD]) begin
        res = '{speed: SPD_10, duplex: DUP_FULL};
      end else begin
        res = '{speed: SPD_10, duplex: DUP_HALF};
      end
    end
    return res;
  endfunction : resolve_rate

  // Pattern building blocks
  always_comb begin
    flash_green = phase ? LED_GREEN : LED_OFF;
    flash_red = phase ? LED_RED : LED_OFF;
    alt_gr = phase ? LED_GREEN : LED_RED;
    major_now = (r_reg.mode == ST_FAULT) || status.major_fault;
  end

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    r_next = r_reg;
    // phy_in pins cross into the clock domain before anything reads them; rx_frame is read without synchronisation
    r_next.phy_s1 = phy_in;
    r_next.phy_s2 = r_reg.phy_s1;

    // Activity is stretched to whole blink periods so short bursts still show
    r_next.act_seen = r_reg.act_seen | (|r_reg.phy_s2.act);
    if (tick) begin
      r_next.act_on = r_next.act_seen;
      r_next.act_seen = |r_reg.phy_s2.act;
    end

    // Start-up sequence; fault state is left only by reset
    case (r_reg.mode)
      ST_SELFTEST: begin
        if (tick) begin
          r_next.st_cnt = r_reg.st_cnt + 4'h1;
          if (r_reg.st_cnt == SELFTEST_PERIODS - 4'h1) begin
            r_next.mode = ST_RUN;
            r_next.dual = r_reg.phy_s2.dual;
          end
        end
      end
      ST_RUN: begin
        r_next.mode = ST_RUN;
      end
      ST_FAULT: begin
        r_next.mode = ST_FAULT;
      end
      default: begin
        r_next.mode = ST_SELFTEST;
      end
    endcase
    if (status.major_fault && r_reg.mode != ST_SELFTEST) begin
      r_next.mode = ST_FAULT;
    end
    if (status.dup_ip && r_reg.mode != ST_SELFTEST) begin
      r_next.dup_lat = 1'b1;
    end

    // Module indicator, highest priority first
    if (r_reg.mode == ST_SELFTEST) begin
      r_next.ms_led = alt_gr;
    end else if (major_now) begin
      r_next.ms_led = LED_RED;
    end else if (status.recov_fault) begin
      r_next.ms_led = flash_red;
    end else if (status.scanner_run) begin
      r_next.ms_led = LED_GREEN;
    end else begin
      r_next.ms_led = flash_green;
    end

    // Network indicator; a latched fault outranks a missing address
    if (r_reg.mode == ST_SELFTEST) begin
      r_next.ns_led = alt_gr;
    end else if (major_now || r_reg.dup_lat || status.dup_ip) begin
      r_next.ns_led = LED_RED;
    end else if (!r_reg.ip_valid) begin
      r_next.ns_led = LED_OFF;
    end else if (status.io_conn_timeout) begin
      r_next.ns_led = flash_red;
    end else if (status.io_conn_active) begin
      r_next.ns_led = LED_GREEN;
    end else begin
      r_next.ns_led = flash_green;
    end

    // Link indicator
    if (!(|r_reg.phy_s2.link)) begin
      r_next.link_led = LED_OFF;
    end else if (r_reg.act_on) begin
      r_next.link_led = flash_green;
    end else begin
      r_next.link_led = LED_GREEN;
    end

    // Rate per port
    for (int p = 0; p < 2; p++) begin
      r_next.rate[p] = resolve_rate(r_reg.phy_s2.abil[p], autoneg_en, forced_rate);
    end

    // Address source
    if (dhcp_en) begin
      r_next.ip = dhcp_ip;
      r_next.ip_valid = dhcp_lease_valid;
    end else begin
      r_next.ip = static_ip;
      r_next.ip_valid = static_ip_valid;
    end

    // Master owns control data while cyclic exchange runs
    if (status.scanner_run) begin
      if (master_valid) begin
        r_next.ctrl = master_ctrl;
      end
    end else if (web_wr) begin
      r_next.ctrl = web_ctrl;
    end

    // Switch forwards a frame to the other port when that port has link
    r_next.fwd[1] = r_reg.dual && rx_frame[0] && r_reg.phy_s2.link[1];
    r_next.fwd[0] = r_reg.dual && rx_frame[1] && r_reg.phy_s2.link[0];

    r_next.mac = MAC_ADDR;
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.mac <= MAC_ADDR;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign ms_led = r_reg.ms_led;
  assign ns_led = r_reg.ns_led;
  assign link_led = r_reg.link_led;
  assign port_rate = r_reg.rate;
  assign ip_cfg = r_reg.ip;
  assign ip_valid = r_reg.ip_valid;
  assign ctrl_word = r_reg.ctrl;
  assign fwd_to_port = r_reg.fwd;
  assign mac_addr = r_reg.mac;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_ms_green;
    r_reg.mode == ST_RUN && !status.major_fault && !status.recov_fault
      && status.scanner_run |=> ms_led == LED_GREEN;
  endproperty
  a_ms_green: assert property (p_ms_green) else $error("module led not green");

  property p_ms_flash_green;
    r_reg.mode == ST_RUN && !status.major_fault && !status.recov_fault
      && !status.scanner_run |=> !ms_led.red && ms_led.green == $past(phase);
  endproperty
  a_ms_flash_green: assert property (p_ms_flash_green) else $error("module led not flashing green");

  property p_ms_major;
    r_reg.mode == ST_FAULT |=> r_reg.mode == ST_FAULT && ms_led == LED_RED
      ##1 ms_led == LED_RED;
  endproperty
  a_ms_major: assert property (p_ms_major) else $error("major fault not held red");

  property p_ms_recov;
    r_reg.mode == ST_RUN && !status.major_fault && status.recov_fault
      |=> !ms_led.green && ms_led.red == $past(phase);
  endproperty
  a_ms_recov: assert property (p_ms_recov) else $error("module led not flashing red");

  property p_selftest;
    r_reg.mode == ST_SELFTEST |=> ms_led.green == $past(phase)
      && ms_led.red == !$past(phase) && ns_led == ms_led;
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-diagnosis pattern wrong");

  property p_ns_off;
    r_reg.mode == ST_RUN && !r_reg.dup_lat && !status.dup_ip && !status.major_fault
      && !r_reg.ip_valid |=> ns_led == LED_OFF;
  endproperty
  a_ns_off: assert property (p_ns_off) else $error("network led lit without address");

  property p_ns_green;
    r_reg.mode == ST_RUN && !r_reg.dup_lat && !status.dup_ip && !status.major_fault
      && r_reg.ip_valid && !status.io_conn_timeout && status.io_conn_active
      |=> ns_led == LED_GREEN;
  endproperty
  a_ns_green: assert property (p_ns_green) else $error("network led not green");

  property p_ns_dup;
    r_reg.mode == ST_RUN && status.dup_ip |=> r_reg.dup_lat && ns_led == LED_RED
      ##1 ns_led == LED_RED;
  endproperty
  a_ns_dup: assert property (p_ns_dup) else $error("duplicate address not held red");

  property p_ns_timeout;
    r_reg.mode == ST_RUN && !r_reg.dup_lat && !status.dup_ip && !status.major_fault
      && r_reg.ip_valid && status.io_conn_timeout
      |=> !ns_led.green && ns_led.red == $past(phase);
  endproperty
  a_ns_timeout: assert property (p_ns_timeout) else $error("timeout not flashing red");

  property p_link_off;
    r_reg.phy_s2.link == 2'h0 |=> link_led == LED_OFF;
  endproperty
  a_link_off: assert property (p_link_off) else $error("link led lit without link");

  property p_web_blocked;
    status.scanner_run && !master_valid |=> ctrl_word == $past(ctrl_word);
  endproperty
  a_web_blocked: assert property (p_web_blocked) else $error("web write took effect online");

  c_run_green: cover property (r_reg.mode == ST_RUN ##1 ms_led == LED_GREEN);
  c_fault: cover property (r_reg.mode == ST_FAULT);
  c_link_flash: cover property (r_reg.act_on && link_led == LED_OFF ##1 link_led == LED_GREEN);
  c_web_write: cover property (!status.scanner_run && web_wr);

endmodule : emsi_top

// [common/emsi_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the Ethernet module status indicators
// Assumes: One 25 MHz clock, asynchronous active-low reset
// Notes: Functional notes follow
//////////////////////////////////////////////////////////////////////////////
package emsi_pkg;

  // Clock and blink timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BLINK_PERIOD_MS = 500;
  localparam int unsigned BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_PERIOD_MS;
  localparam int unsigned BLINK_CNT_W = 24;
  localparam logic [3:0] SELFTEST_PERIODS = 4'h4;

  // Partner ability bit positions and rate encodings
  localparam int unsigned ABIL_10HD = 0;
  localparam int unsigned ABIL_10FD = 1;
  localparam int unsigned ABIL_100HD = 2;
  localparam int unsigned ABIL_100FD = 3;
  localparam logic SPD_10 = 1'b0;
  localparam logic SPD_100 = 1'b1;
  localparam logic DUP_HALF = 1'b0;
  localparam logic DUP_FULL = 1'b1;

  // Identity value is arbitrary, locally administered
  localparam logic [47:0] MAC_DEFAULT = 48'h02_00_00_00_00_01;

  // Start-up modes, Gray coded along selftest, run, fault
  typedef enum logic [1:0] {
    ST_SELFTEST = 2'b00,
    ST_RUN = 2'b01,
    ST_FAULT = 2'b11
  } emsi_mode_type;

  typedef struct packed {
    logic green;
    logic red;
  } emsi_led_type;

  localparam emsi_led_type LED_OFF = 2'b00;
  localparam emsi_led_type LED_GREEN = 2'b10;
  localparam emsi_led_type LED_RED = 2'b01;

  // Condition reported by the protocol firmware
  typedef struct packed {
    logic scanner_run;
    logic major_fault;
    logic recov_fault;
    logic io_conn_active;
    logic io_conn_timeout;
    logic dup_ip;
  } emsi_status_type;

  // PHY pins, two ports
  typedef struct packed {
    logic dual;
    logic [1:0] link;
    logic [1:0] act;
    logic [1:0][3:0] abil;
  } emsi_phy_type;

  typedef struct packed {
    logic speed;
    logic duplex;
  } emsi_rate_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] mask;
  } emsi_ip_type;

  typedef struct packed {
    emsi_mode_type mode;
    logic [3:0] st_cnt;
    logic dup_lat;
    logic dual;
    emsi_phy_type phy_s1;
    emsi_phy_type phy_s2;
    logic act_seen;
    logic act_on;
    emsi_led_type ms_led;
    emsi_led_type ns_led;
    emsi_led_type link_led;
    emsi_rate_type [1:0] rate;
    emsi_ip_type ip;
    logic ip_valid;
    logic [15:0] ctrl;
    logic [1:0] fwd;
    logic [47:0] mac;
  } emsi_state_type;

  typedef struct packed {
    logic [BLINK_CNT_W-1:0] cnt;
    logic phase;
    logic tick;
  } emsi_blink_state_type;

endpackage : emsi_pkg

// [design/emsi_blink.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Common blink timebase for all flashing indicators
// Assumes: PERIOD of at least 2 cycles, below 2**BLINK_CNT_W
// Notes: phase is high in the first half period, tick pulses at period end
//////////////////////////////////////////////////////////////////////////////
module emsi_blink #(
  parameter int unsigned PERIOD = emsi_pkg::BLINK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Timebase
  output logic phase,
  output logic tick
);
  import emsi_pkg::*;

  localparam logic [BLINK_CNT_W-1:0] LAST = BLINK_CNT_W'(PERIOD - 1);
  localparam logic [BLINK_CNT_W-1:0] HALF = BLINK_CNT_W'(PERIOD / 2);

  emsi_blink_state_type r_reg, r_next;

  // One shared counter keeps every flashing indicator in step
  always_comb begin
    r_next = r_reg;
    r_next.tick = (r_reg.cnt == LAST);
    r_next.cnt = (r_reg.cnt == LAST) ? '0 : r_reg.cnt + 1'b1;
    r_next.phase = (r_next.cnt < HALF);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign phase = r_reg.phase;
  assign tick = r_reg.tick;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_blink_tick;
    @(posedge clk) disable iff (!resetn)
      tick |=> !tick;
  endproperty
  a_blink_tick: assert property (p_blink_tick) else $error("blink tick longer than one cycle");

endmodule : emsi_blink

// [test/emsi_scanner_model.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Behavioural network scanner facing the status block
// Assumes: Bench steers it by levels between rising edges; outputs move on the rising edge
// Notes: The control bus toggles between words so a stale value never looks valid
//////////////////////////////////////////////////////////////////////////////
module emsi_scanner_model #(
  parameter int unsigned GAP = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Commands from the bench
  input wire logic run_cmd,
  input wire logic conn_cmd,
  input wire logic lost_cmd,
  input wire logic [15:0] word,
  // Toward the device
  output logic scanner_run,
  output logic io_conn_active,
  output logic io_conn_timeout,
  output logic master_valid,
  output logic [15:0] master_ctrl
);
  timeunit 1ns;
  timeprecision 1ns;

  int gap_cnt;

  // One cyclic word every GAP cycles while running, inverted filler between words
  // Commands are read on the rising edge so they never race the bench's falling-edge writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scanner_run <= 1'b0;
      io_conn_active <= 1'b0;
      io_conn_timeout <= 1'b0;
      master_valid <= 1'b0;
      master_ctrl <= 16'h0000;
      gap_cnt <= 0;
    end else begin
      scanner_run <= run_cmd;
      io_conn_active <= conn_cmd & ~lost_cmd;
      io_conn_timeout <= lost_cmd;
      gap_cnt <= (gap_cnt == GAP - 1) ? 0 : gap_cnt + 1;
      master_valid <= run_cmd && (gap_cnt == 0);
      master_ctrl <= (run_cmd && (gap_cnt == 0)) ? word : ~master_ctrl;
    end
  end
endmodule : emsi_scanner_model

// [test/emsi_top_test.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the status indicator block
// Assumes: Short blink period so each flash pattern fits in 8 cycles
// Notes: Patterns are judged by counting lit cycles over one blink period
//////////////////////////////////////////////////////////////////////////////
module emsi_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import emsi_pkg::*;

  localparam int unsigned BP = 8;
  localparam logic [47:0] MAC = 48'h0A_1B_2C_3D_4E_5F; // Arbitrary value

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic maj, rec, dup, run_cmd, conn_cmd, lost_cmd;
  logic [15:0] word;
  emsi_status_type status;
  emsi_phy_type phy_in;
  logic [1:0] rx_frame;
  logic autoneg_en, dhcp_en, dhcp_lease_valid, static_ip_valid;
  emsi_rate_type forced_rate;
  emsi_ip_type dhcp_ip, static_ip;
  logic m_run, m_conn, m_tmo, master_valid, web_wr, ip_valid;
  logic [15:0] master_ctrl, web_ctrl, ctrl_word;
  emsi_led_type ms_led, ns_led, link_led;
  emsi_rate_type [1:0] port_rate;
  emsi_ip_type ip_cfg;
  logic [1:0] fwd_to_port;
  logic [47:0] mac_addr;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Firmware status is the scanner's view plus the bench's fault levels
  assign status = {m_run, maj, rec, m_conn, m_tmo, dup};

  always #20 clk = ~clk;

  emsi_scanner_model scan_u (.clk(clk), .resetn(resetn), .run_cmd(run_cmd),
    .conn_cmd(conn_cmd), .lost_cmd(lost_cmd), .word(word), .scanner_run(m_run),
    .io_conn_active(m_conn), .io_conn_timeout(m_tmo), .master_valid(master_valid),
    .master_ctrl(master_ctrl));

  emsi_top #(.BLINK_PERIOD(BP), .MAC_ADDR(MAC)) dut_u (.clk(clk), .resetn(resetn),
    .status(status), .phy_in(phy_in), .rx_frame(rx_frame), .autoneg_en(autoneg_en),
    .forced_rate(forced_rate), .dhcp_en(dhcp_en), .dhcp_ip(dhcp_ip),
    .dhcp_lease_valid(dhcp_lease_valid), .static_ip(static_ip),
    .static_ip_valid(static_ip_valid), .master_valid(master_valid),
    .master_ctrl(master_ctrl), .web_wr(web_wr), .web_ctrl(web_ctrl), .ms_led(ms_led),
    .ns_led(ns_led), .link_led(link_led), .port_rate(port_rate), .ip_cfg(ip_cfg),
    .ip_valid(ip_valid), .ctrl_word(ctrl_word), .fwd_to_port(fwd_to_port),
    .mac_addr(mac_addr));

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("Errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // A hang ends the run through the same report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("BAD %0t run did not finish", $time);
      final_report();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  // Lit green and red cycles over one blink period; an unknown cycle spoils the count
  task automatic led_is(input int sel, input int eg, input int er, input string what);
    emsi_led_type l;
    int g;
    int r;
    g = 0;
    r = 0;
    repeat (BP) begin
      @(negedge clk);
      l = (sel == 0) ? ms_led : (sel == 1) ? ns_led : link_led;
      g += (l.green === 1'b1) ? 1 : (l.green === 1'b0) ? 0 : BP + 1;
      r += (l.red === 1'b1) ? 1 : (l.red === 1'b0) ? 0 : BP + 1;
    end
    chk({g[31:0], r[31:0]}, {eg[31:0], er[31:0]}, what);
  endtask : led_is

  // Reset, then self-test pattern on both indicators until run mode
  task automatic do_reset;
    resetn = 1'b0;
    settle(5);
    chk(mac_addr, MAC, "mac in reset");
    resetn = 1'b1;
    settle(2);
    led_is(0, BP / 2, BP / 2, "ms self-test");
    led_is(1, BP / 2, BP / 2, "ns self-test");
    settle(4 * BP);
    chk(mac_addr, MAC, "mac running");
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_module;
    settle(3);
    led_is(0, BP / 2, 0, "ms idle flash");
    run_cmd = 1'b1;
    settle(3);
    led_is(0, BP, 0, "ms run green");
    rec = 1'b1;
    settle(3);
    led_is(0, 0, BP / 2, "ms recoverable");
    rec = 1'b0;
    settle(3);
    led_is(0, BP, 0, "ms recovered");
  endtask : t_module

  task automatic t_network;
    led_is(1, 0, 0, "ns no address");
    static_ip_valid = 1'b1;
    settle(3);
    chk(ip_cfg, static_ip, "static address");
    led_is(1, BP / 2, 0, "ns online");
    conn_cmd = 1'b1;
    settle(3);
    led_is(1, BP, 0, "ns connected");
    lost_cmd = 1'b1;
    settle(3);
    led_is(1, 0, BP / 2, "ns timeout");
    lost_cmd = 1'b0;
    dhcp_en = 1'b1;
    dhcp_lease_valid = 1'b1;
    settle(3);
    chk(ip_cfg, dhcp_ip, "dhcp address");
    chk(ip_valid, 1, "dhcp valid");
    dhcp_lease_valid = 1'b0;
    settle(3);
    chk(ip_valid, 0, "no lease");
    dhcp_lease_valid = 1'b1;
  endtask : t_network

  // Web write refused while master runs, taken once offline
  task automatic t_control;
    settle(2 * 4);
    chk(ctrl_word, 16'hA5C3, "master word");
    web_wr = 1'b1;
    settle(1);
    web_wr = 1'b0;
    settle(2);
    chk(ctrl_word, 16'hA5C3, "web refused");
    run_cmd = 1'b0;
    settle(3);
    web_wr = 1'b1;
    settle(1);
    web_wr = 1'b0;
    settle(1);
    chk(ctrl_word, 16'h3C5A, "web taken");
    run_cmd = 1'b1;
  endtask : t_control

  task automatic t_link;
    led_is(2, 0, 0, "no link");
    phy_in.link[0] = 1'b1;
    settle(5);
    led_is(2, BP, 0, "link quiet");
    phy_in.act[0] = 1'b1;
    settle(3 * BP);
    led_is(2, BP / 2, 0, "link active");
    phy_in.act[0] = 1'b0;
    settle(3 * BP);
    led_is(2, BP, 0, "link quiet again");
  endtask : t_link

  task automatic t_rate;
    logic [3:0] ab [4] = '{4'h0, 4'h3, 4'h4, 4'hF};
    logic [1:0] ex [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
    for (int i = 0; i < 4; i++) begin
      phy_in.abil[0] = ab[i];
      settle(5);
      chk(port_rate[0], ex[i], "auto rate");
    end
    chk(port_rate[1], 2'b00, "idle port rate");
    autoneg_en = 1'b0;
    settle(5);
    chk(port_rate[0], 2'b10, "forced rate");
  endtask : t_rate

  // A frame on port 0 reaches port 1 only when that port has link
  task automatic t_fwd;
    int n;
    for (int lk = 0; lk < 2; lk++) begin
      phy_in.link[1] = lk[0];
      settle(5);
      rx_frame = 2'b01;
      n = 0;
      repeat (4) begin
        @(negedge clk);
        rx_frame = 2'b00;
        n += (fwd_to_port[1] === 1'b1);
      end
      chk(n, lk, "forward pulses");
    end
    // Port 0 has had link since the link test, so a frame on port 1 goes there only
    settle(1);
    rx_frame = 2'b10;
    settle(1);
    rx_frame = 2'b00;
    chk(fwd_to_port, 2'b01, "forward to port 0");
  endtask : t_fwd

  task automatic t_faults;
    maj = 1'b1;
    settle(3);
    maj = 1'b0;
    settle(2);
    led_is(0, 0, BP, "ms major held");
    led_is(1, 0, BP, "ns major held");
    do_reset();
    led_is(0, BP, 0, "ms after reinit");
    dup = 1'b1;
    settle(3);
    dup = 1'b0;
    settle(2);
    led_is(1, 0, BP, "ns duplicate held");
    led_is(0, BP, 0, "ms ignores duplicate");
  endtask : t_faults

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence; every input has a value at time zero
  initial begin
    {maj, rec, dup, run_cmd, conn_cmd, lost_cmd, web_wr, rx_frame} = '0;
    {dhcp_en, dhcp_lease_valid, static_ip_valid} = '0;
    word = 16'hA5C3;
    web_ctrl = 16'h3C5A;
    phy_in = '0;
    phy_in.dual = 1'b1;
    autoneg_en = 1'b1;
    forced_rate = 2'b10;
    dhcp_ip = 64'hC0A8_0A14_FFFF_FF00;
    static_ip = 64'h0A00_0005_FF00_0000;
    do_reset();
    t_module();
    t_network();
    t_control();
    t_link();
    t_rate();
    t_fwd();
    t_faults();
    final_report();
  end
endmodule : emsi_top_test
